// ---- design/wdtsl_pkg.sv ----
// package for the watchdog status and write-guard block
// assumes a 32-bit AXI4-Lite register bus on the system clock
package wdtsl_pkg;
	// register byte offsets
	localparam logic [11:0] off_interval_reload = 12'h000;
	localparam logic [11:0] off_count_value = 12'h004;
	localparam logic [11:0] off_control = 12'h008;
	localparam logic [11:0] off_interrupt_clear = 12'h00c;
	localparam logic [11:0] off_raw_status = 12'h010;
	localparam logic [11:0] off_masked_status = 12'h014;
	localparam logic [11:0] off_write_guard = 12'hc00;
	// key and lock read values
	localparam logic [31:0] guard_key = 32'h1acc_e551;
	localparam logic [31:0] lock_read_locked = 32'h0000_0001;
	localparam logic [31:0] lock_read_unlocked = 32'h0000_0000;
	// reset values
	localparam logic [31:0] reload_reset = 32'hffff_ffff;
	localparam logic [31:0] zero_word = 32'h0000_0000;
	// control field positions
	localparam int ctl_irq_en_bit = 0;
	localparam int ctl_rst_en_bit = 1;
	// axi responses
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// ---- design/wdtsl_top.sv ----
// watchdog timer: down-counter, interrupt status and write guard
// assumes one 100 MHz clock, synchronous active-low reset, AXI4-Lite master
//
// Summary of operation
// - any unlocked write to interrupt_clear drops the pending timeout interrupt
// - that write also reloads the down-counter from interval_reload
// - interrupt_clear is write-only; its reads return zero
// - raw_timeout_status bit 0 shows the unmasked timeout interrupt
// - masked status is raw bit AND timeout_irq_enable
// - writing the guard key to write_guard unlocks all other registers
// - any other write_guard value locks; locked writes to others are dropped
// - write_guard reads one while locked, zero while unlocked
// - once timeout_irq_enable is set, control writes ignored until reset
// - writing interval_reload loads the counter immediately and restarts
// - with reset output enabled, second consecutive timeout asserts reset
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wdtsl_top
	import wdtsl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// watchdog outputs
	output logic timeout_irq,
	output logic wdt_reset
);

	// ==========================================================
	// write channel capture
	logic aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_held && w_held && !s_axi_bvalid;

	// address and data are accepted in either order, one write at a time
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= zero_word;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= !aw_held && !aw_take && !wr_go;
			s_axi_wready <= !w_held && !w_take && !wr_go;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// ==========================================================
	// write decode: guard always writable, others only when unlocked
	logic locked;
	wire wr_guard = wr_go && aw_addr == off_write_guard;
	wire wr_ok = wr_go && !locked;
	wire wr_reload = wr_ok && aw_addr == off_interval_reload;
	wire wr_ctl = wr_ok && aw_addr == off_control;
	wire wr_iclr = wr_ok && aw_addr == off_interrupt_clear;
	wire wr_mapped = aw_addr == off_write_guard
		|| aw_addr == off_interval_reload || aw_addr == off_control
		|| aw_addr == off_interrupt_clear || aw_addr == off_raw_status
		|| aw_addr == off_masked_status || aw_addr == off_count_value;

	// merge byte lanes into the reload word
	logic [31:0] reload;
	logic [31:0] next_reload;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			next_reload[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8]
				: reload[i*8 +: 8];
		end
	end

	// write response, slverr for unmapped offsets
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? resp_okay : resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// write guard: key unlocks, anything else locks
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			locked <= 1'b0;
		end else if (wr_guard) begin
			locked <= (w_data != guard_key);
		end
	end

	// ==========================================================
	// control: sticky once the interrupt enable is set
	logic irq_en, rst_en;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_en <= 1'b0;
			rst_en <= 1'b0;
		end else if (wr_ctl && !irq_en && w_strb[0]) begin
			irq_en <= w_data[ctl_irq_en_bit];
			rst_en <= w_data[ctl_rst_en_bit];
		end
	end

	// ==========================================================
	// down-counter and timeout status
	logic [31:0] count;
	logic raw;
	wire at_zero = count == zero_word;
	// counting only runs once enabled; zero reload times out at once
	wire timeout = irq_en && at_zero && !wr_reload && !wr_iclr;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			reload <= reload_reset;
			count <= reload_reset;
		end else if (wr_reload) begin
			reload <= next_reload;
			count <= next_reload;
		end else if (wr_iclr || timeout) begin
			count <= reload;
		end else if (irq_en) begin
			count <= count - 32'h0000_0001;
		end
	end

	// a timeout in the clear cycle cannot occur: wr_iclr masks timeout
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			raw <= 1'b0;
			wdt_reset <= 1'b0;
			timeout_irq <= 1'b0;
		end else begin
			if (timeout) begin
				raw <= 1'b1;
			end else if (wr_iclr) begin
				raw <= 1'b0;
			end
			if (timeout && raw && rst_en) begin
				wdt_reset <= 1'b1;
			end
			timeout_irq <= irq_en && (timeout || (raw && !wr_iclr));
		end
	end

	// ==========================================================
	// read path, one read at a time
	wire ar_take = s_axi_arvalid && s_axi_arready;
	logic [31:0] rd_word;
	logic rd_hit;
	wire [31:0] ctl_word = {30'h0000_0000, rst_en, irq_en};
	always_comb begin
		rd_hit = 1'b1;
		if (s_axi_araddr == off_interval_reload) rd_word = reload;
		else if (s_axi_araddr == off_count_value) rd_word = count;
		else if (s_axi_araddr == off_control) rd_word = ctl_word;
		else if (s_axi_araddr == off_interrupt_clear) rd_word = zero_word;
		else if (s_axi_araddr == off_raw_status) rd_word = {31'h0, raw};
		else if (s_axi_araddr == off_masked_status)
			rd_word = {31'h0, raw & irq_en};
		else if (s_axi_araddr == off_write_guard)
			rd_word = locked ? lock_read_locked : lock_read_unlocked;
		else begin
			rd_word = zero_word;
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= zero_word;
			s_axi_rresp <= resp_okay;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// checks
	sequence guard_write_s;
		wr_guard;
	endsequence

	unlock_key_a: assert property (@(posedge mclk) disable iff (!nrst)
		guard_write_s and w_data == guard_key |=> !locked)
		else $error("key write did not unlock");
	relock_a: assert property (@(posedge mclk) disable iff (!nrst)
		guard_write_s and w_data != guard_key |=> locked)
		else $error("non-key write did not lock");
	locked_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		wr_go && locked && aw_addr == off_interval_reload
		|=> $stable(reload))
		else $error("locked write changed reload");
	iclr_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
		wr_iclr |=> !raw)
		else $error("clear left raw status set");
	iclr_reload_a: assert property (@(posedge mclk) disable iff (!nrst)
		wr_iclr |=> count == $past(reload))
		else $error("clear did not reload counter");
	reload_load_a: assert property (@(posedge mclk) disable iff (!nrst)
		wr_reload |=> count == reload)
		else $error("reload write not loaded");
	ctl_sticky_a: assert property (@(posedge mclk) disable iff (!nrst)
		irq_en |=> irq_en && $stable(rst_en))
		else $error("control changed after enable");
	raw_set_a: assert property (@(posedge mclk) disable iff (!nrst)
		timeout |=> raw ##1 (raw || $past(wr_iclr)))
		else $error("raw status not held");
	masked_read_a: assert property (@(posedge mclk) disable iff (!nrst)
		ar_take && s_axi_araddr == off_masked_status
		|=> s_axi_rdata[0] == $past(raw && irq_en))
		else $error("masked status wrong");
	lock_read_a: assert property (@(posedge mclk) disable iff (!nrst)
		ar_take && s_axi_araddr == off_write_guard
		|=> s_axi_rdata == {31'h0, $past(locked)})
		else $error("lock read wrong");
	second_rst_a: assert property (@(posedge mclk) disable iff (!nrst)
		timeout && raw && rst_en |=> wdt_reset)
		else $error("second timeout gave no reset");
	reset_state_a: assert property (@(posedge mclk)
		!nrst |=> !locked && !raw && !timeout_irq)
		else $error("reset state wrong");
	raw_read_a: assert property (@(posedge mclk) disable iff (!nrst)
		ar_take && s_axi_araddr == off_raw_status
		|=> s_axi_rdata[0] == $past(raw))
		else $error("raw status read wrong");

endmodule
`default_nettype wire

// ---- dv/test_watchdog_irq_status_and_lock.sv ----
// self-checking bench for the watchdog status and write-guard block
// assumes wdtsl_pkg offsets and an AXI4-Lite slave that answers in time
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_watchdog_irq_status_and_lock
	import wdtsl_pkg::*;
;
	// ==========================================================
	// bench signals
	logic mclk = 1'b0, nrst = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, timeout_irq, wdt_reset;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	int failures = 0, checks_done = 0;
	wdtsl_top dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.timeout_irq(timeout_irq), .wdt_reset(wdt_reset));
	// 100 MHz clock
	initial begin
		forever #5 mclk = ~mclk;
	end
	// ==========================================================
	// verdict and bounded waits
	task automatic close_out();
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic tick(inout int n);
		@(posedge mclk);
		n++;
		if (n > 600) begin
			failures++;
			close_out();
		end
	endtask
	// ==========================================================
	// bus cycles: payload held until its own ready is sampled
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			tick(n);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rdr(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			tick(n);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	// sel 0 waits for the interrupt, 1 for the reset output
	task automatic wait_out(input bit sel);
		int n;
		n = 0;
		while ((sel ? wdt_reset : timeout_irq) !== 1'b1) tick(n);
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask
	// ==========================================================
	// scenarios
	task automatic sc_reset_and_guard();
		rdr(off_write_guard);
		`CHK("guard reset", lock_read_unlocked, rd)
		rdr(off_raw_status);
		`CHK("raw reset", zero_word, rd)
		rdr(off_masked_status);
		`CHK("masked reset", zero_word, rd)
		wr(off_write_guard, 32'h1acc_e550);
		rdr(off_write_guard);
		`CHK("guard locked", lock_read_locked, rd)
		wr(off_interval_reload, 32'h0000_1234);
		rdr(off_interval_reload);
		`CHK("locked reload", reload_reset, rd)
		wr(off_write_guard, guard_key);
		`CHK("guard resp", resp_okay, rsp)
		rdr(off_write_guard);
		`CHK("guard open", lock_read_unlocked, rd)
		wr(off_interval_reload, 32'h0000_1234);
		rdr(off_interval_reload);
		`CHK("open reload", 32'h0000_1234, rd)
		rdr(off_count_value);
		`CHK("open count", 32'h0000_1234, rd)
		rdr(12'h100);
		`CHK("unmapped resp", resp_slverr, rsp)
	endtask
	// a clear written while locked must not drop the interrupt
	task automatic sc_timeout_clear();
		wr(off_interval_reload, 32'h0000_0040);
		wr(off_control, 32'h0000_0001);
		wait_out(1'b0);
		repeat (30) @(posedge mclk);
		rdr(off_raw_status);
		`CHK("raw set", 32'h0000_0001, rd)
		rdr(off_masked_status);
		`CHK("masked set", 32'h0000_0001, rd)
		wr(off_write_guard, zero_word);
		wr(off_interrupt_clear, zero_word);
		@(posedge mclk);
		`CHK("locked clear", 1'b1, timeout_irq)
		wr(off_write_guard, guard_key);
		wr(off_interrupt_clear, 32'h0000_5a5a);
		@(posedge mclk);
		`CHK("irq cleared", 1'b0, timeout_irq)
		rdr(off_count_value);
		// a missed reload would leave the counter anywhere in its period
		`CHK("count reloaded", 1'b1,
			rd <= 32'h0000_0040 && rd >= 32'h0000_0038)
		rdr(off_raw_status);
		`CHK("raw cleared", zero_word, rd)
		rdr(off_interrupt_clear);
		`CHK("clear read", zero_word, rd)
		wr(off_control, zero_word);
		rdr(off_control);
		`CHK("control frozen", 32'h0000_0001, rd)
		`CHK("no reset out", 1'b0, wdt_reset)
	endtask
	// first timeout interrupts, the second one resets
	task automatic sc_second_timeout();
		do_reset();
		wr(off_interval_reload, 32'h0000_0040);
		wr(off_control, 32'h0000_0003);
		wait_out(1'b0);
		`CHK("first timeout", 1'b0, wdt_reset)
		wait_out(1'b1);
		`CHK("second timeout", 1'b1, timeout_irq)
		// lock and keep status set, then check that reset clears it all
		wr(off_write_guard, zero_word);
		do_reset();
		`CHK("reset out cleared", 1'b0, wdt_reset)
		rdr(off_write_guard);
		`CHK("guard after reset", lock_read_unlocked, rd)
		rdr(off_raw_status);
		`CHK("raw after reset", zero_word, rd)
		rdr(off_masked_status);
		`CHK("masked after reset", zero_word, rd)
		// only a reset makes control writable again
		wr(off_control, 32'h0000_0002);
		rdr(off_control);
		`CHK("control reopened", 32'h0000_0002, rd)
	endtask
	// ==========================================================
	// main sequence
	initial begin
		do_reset();
		sc_reset_and_guard();
		sc_timeout_clear();
		sc_second_timeout();
		close_out();
	end
endmodule
`default_nettype wire
